// [rtl/ipr_pkg.sv]
// ipr_pkg: constants shared by the interrupt priority register bank
// assumes: 32-bit axi4-lite register bus, 16-bit priority registers
package ipr_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] IPR_OFF_GROUP_6 = 8'h00;
  localparam logic [7:0] IPR_OFF_GROUP_7 = 8'h04;
  localparam logic [7:0] IPR_OFF_GROUP_8 = 8'h08;
  localparam logic [7:0] IPR_OFF_GROUP_CAPTURE = 8'h0C;
  localparam int IPR_REG_COUNT = 4;
  localparam int IPR_REG_W = 16;
  localparam int IPR_DATA_W = 32;

  // ---------------------------------------------------------------
  // field layout: four 3-bit fields per register
  // ---------------------------------------------------------------
  localparam int IPR_FIELD_W = 3;
  localparam int IPR_FIELDS_PER_REG = 4;
  localparam int IPR_SRC_COUNT = 16;
  localparam int IPR_FIELD_HI_LSB = 12;
  localparam int IPR_FIELD_MH_LSB = 8;
  localparam int IPR_FIELD_ML_LSB = 4;
  localparam int IPR_FIELD_LO_LSB = 0;
  localparam logic [15:0] IPR_IMPL_MASK = 16'h7777;
  localparam logic [15:0] IPR_RESET_VALUE = 16'h4444;

  // ---------------------------------------------------------------
  // priority encodings
  // ---------------------------------------------------------------
  localparam logic [2:0] IPR_PRIO_OFF = 3'h0;
  localparam logic [2:0] IPR_PRIO_MIN = 3'h1;
  localparam logic [2:0] IPR_PRIO_MAX = 3'h7;

  // ---------------------------------------------------------------
  // axi4-lite responses
  // ---------------------------------------------------------------
  localparam logic [1:0] IPR_RESP_OKAY = 2'h0;
  localparam logic [1:0] IPR_RESP_SLVERR = 2'h2;

  typedef logic [IPR_REG_W-1:0] ipr_word_t;
  typedef logic [IPR_FIELD_W-1:0] ipr_prio_t;

endpackage : ipr_pkg

// [rtl/ipr_field_bank.sv]
// ipr_field_bank: one 16-bit priority register with byte strobes
// assumes: write strobe is a one-cycle pulse from the bus slave
`timescale 1ns/100ps
`default_nettype none
module ipr_field_bank
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire ipr_pkg::ipr_word_t wr_data,
  input wire logic [1:0] wr_strb,
  output ipr_pkg::ipr_word_t value
);
  import ipr_pkg::*;

  typedef struct packed
  {
    ipr_word_t value;
  } ipr_bank_state_t;

  ipr_bank_state_t s;
  ipr_bank_state_t next_s;

  // byte-lane merge; gap bits are never stored so they read zero
  always_comb
  begin
    next_s = s;
    if (wr_en)
    begin
      if (wr_strb[0])
        next_s.value[7:0] = wr_data[7:0];
      if (wr_strb[1])
        next_s.value[15:8] = wr_data[15:8];
      next_s.value = next_s.value & IPR_IMPL_MASK;
    end
  end

  // every field comes up at the middle level
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      s <= '{value: IPR_RESET_VALUE};
    else
      s <= next_s;
  end

  assign value = s.value;

endmodule : ipr_field_bank
`default_nettype wire

// [rtl/ipr_gate.sv]
// ipr_gate: turns source flags into requests using their priorities
// assumes: flags are synchronous levels from the peripherals
`timescale 1ns/100ps
`default_nettype none
module ipr_gate
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] src_flag,
  input wire logic [47:0] src_prio,
  output logic [15:0] irq_request
);
  import ipr_pkg::*;

  typedef struct packed
  {
    logic [15:0] req;
  } ipr_gate_state_t;

  ipr_gate_state_t s;
  ipr_gate_state_t next_s;

  // a zero field masks the source whatever its flag does
  always_comb
  begin
    next_s = s;
    for (int i = 0; i < IPR_SRC_COUNT; i++)
      next_s.req[i] = src_flag[i] &&
        (src_prio[i*IPR_FIELD_W +: IPR_FIELD_W] != IPR_PRIO_OFF);
  end

  // registered so the top's outputs come straight from flops
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      s <= '{req: 16'h0000};
    else
      s <= next_s;
  end

  assign irq_request = s.req;

endmodule : ipr_gate
`default_nettype wire

// [rtl/ipr_top.sv]
// ipr_top: four interrupt priority registers behind an axi4-lite slave
// assumes: one clock, async active-low reset, master obeys axi4-lite
`timescale 1ns/100ps
`default_nettype none
module ipr_top
#(
  parameter int ADDR_W = 8
)
(
  input wire logic clk,
  input wire logic rst_b,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // source flags, bit order as in the priority outputs below
  input wire logic [15:0] src_flag,
  // requests of enabled sources
  output logic [15:0] irq_request,
  // priority level of each source
  output ipr_pkg::ipr_prio_t timer4_priority,
  output ipr_pkg::ipr_prio_t compare4_priority,
  output ipr_pkg::ipr_prio_t compare3_priority,
  output ipr_pkg::ipr_prio_t dma_ch2_done_priority,
  output ipr_pkg::ipr_prio_t serial2_tx_priority,
  output ipr_pkg::ipr_prio_t serial2_rx_priority,
  output ipr_pkg::ipr_prio_t ext_irq2_priority,
  output ipr_pkg::ipr_prio_t timer5_priority,
  output ipr_pkg::ipr_prio_t can1_event_priority,
  output ipr_pkg::ipr_prio_t can1_rx_ready_priority,
  output ipr_pkg::ipr_prio_t spi2_event_priority,
  output ipr_pkg::ipr_prio_t spi2_error_priority,
  output ipr_pkg::ipr_prio_t capture5_priority,
  output ipr_pkg::ipr_prio_t capture4_priority,
  output ipr_pkg::ipr_prio_t capture3_priority,
  output ipr_pkg::ipr_prio_t dma_ch3_done_priority
);
  import ipr_pkg::*;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  // the map needs at least the low four address bits to decode
  if (ADDR_W < 4 || ADDR_W > 32)
  begin : g_bad_addr_w
    $error("ipr_top: ADDR_W must lie between 4 and 32");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // decode a byte address to {hit, index}; used by both channels
  function automatic logic [2:0] reg_decode(logic [ADDR_W-1:0] addr);
    logic [7:0] low;
    logic hi_zero;
    low = 8'h00;
    hi_zero = 1'b1;
    for (int i = 0; i < ADDR_W; i++)
    begin
      if (i < 8)
        low[i] = addr[i];
      else if (addr[i])
        hi_zero = 1'b0;
    end
    if (!hi_zero)
      reg_decode = 3'h0;
    else if (low == IPR_OFF_GROUP_6)
      reg_decode = 3'h4;
    else if (low == IPR_OFF_GROUP_7)
      reg_decode = 3'h5;
    else if (low == IPR_OFF_GROUP_8)
      reg_decode = 3'h6;
    else if (low == IPR_OFF_GROUP_CAPTURE)
      reg_decode = 3'h7;
    else
      reg_decode = 3'h0;
  endfunction : reg_decode

  // pick one 3-bit field; the value is the level itself, 7 highest
  function automatic ipr_prio_t field_of(ipr_word_t word, int lsb);
    field_of = word[lsb +: IPR_FIELD_W];
  endfunction : field_of

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed
  {
    logic awready;
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic wready;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ipr_top_state_t;

  ipr_top_state_t s;
  ipr_top_state_t next_s;

  ipr_word_t bank_value [IPR_REG_COUNT];
  logic [IPR_REG_COUNT-1:0] bank_we;
  logic wr_fire;
  logic [2:0] wr_dec;
  logic [2:0] rd_dec;
  logic [47:0] prio_flat;

  assign wr_fire = s.aw_got && s.w_got && !s.bvalid;
  assign wr_dec = reg_decode(s.aw_addr);
  assign rd_dec = reg_decode(araddr);

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  // address and data may arrive in either order; each is held
  // until both are present, then the write lands and answers
  always_comb
  begin
    next_s = s;
    bank_we = '0;
    if (awvalid && s.awready)
    begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && s.wready)
    begin
      next_s.w_got = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end
    if (wr_fire)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      if (wr_dec[2])
      begin
        bank_we[wr_dec[1:0]] = 1'b1;
        next_s.bresp = IPR_RESP_OKAY;
      end
      else
        next_s.bresp = IPR_RESP_SLVERR;
    end
    else if (s.bvalid && bready)
      next_s.bvalid = 1'b0;
    // one write at a time: no new beats while one is unanswered
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;

    // read answers one cycle after the address is taken
    if (arvalid && s.arready)
    begin
      next_s.rvalid = 1'b1;
      if (rd_dec[2])
      begin
        next_s.rdata = {16'h0000, bank_value[rd_dec[1:0]]};
        next_s.rresp = IPR_RESP_OKAY;
      end
      else
      begin
        next_s.rdata = 32'h0000_0000;
        next_s.rresp = IPR_RESP_SLVERR;
      end
    end
    else if (s.rvalid && rready)
      next_s.rvalid = 1'b0;
    next_s.arready = !next_s.rvalid;
  end

  // readies start low and rise one edge after reset is released
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      s <= '0;
    else
      s <= next_s;
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;

  // ---------------------------------------------------------------
  // register bank
  // ---------------------------------------------------------------
  // only the low two byte lanes exist; upper strobes are harmless
  for (genvar g = 0; g < IPR_REG_COUNT; g++)
  begin : g_bank
    ipr_field_bank u_bank
    (
      .clk(clk),
      .rst_b(rst_b),
      .wr_en(bank_we[g]),
      .wr_data(s.w_data[15:0]),
      .wr_strb(s.w_strb[1:0]),
      .value(bank_value[g])
    );
  end

  // ---------------------------------------------------------------
  // field outputs
  // ---------------------------------------------------------------
  // plain wires off the bank flops, so they settle with the register;
  // a changed field reaches its output at the write's answer edge
  // group 6
  assign timer4_priority = field_of(bank_value[0], IPR_FIELD_HI_LSB);
  assign compare4_priority = field_of(bank_value[0], IPR_FIELD_MH_LSB);
  assign compare3_priority = field_of(bank_value[0], IPR_FIELD_ML_LSB);
  assign dma_ch2_done_priority =
    field_of(bank_value[0], IPR_FIELD_LO_LSB);
  // group 7
  assign serial2_tx_priority =
    field_of(bank_value[1], IPR_FIELD_HI_LSB);
  assign serial2_rx_priority =
    field_of(bank_value[1], IPR_FIELD_MH_LSB);
  assign ext_irq2_priority = field_of(bank_value[1], IPR_FIELD_ML_LSB);
  assign timer5_priority = field_of(bank_value[1], IPR_FIELD_LO_LSB);
  // group 8
  assign can1_event_priority =
    field_of(bank_value[2], IPR_FIELD_HI_LSB);
  assign can1_rx_ready_priority =
    field_of(bank_value[2], IPR_FIELD_MH_LSB);
  assign spi2_event_priority =
    field_of(bank_value[2], IPR_FIELD_ML_LSB);
  assign spi2_error_priority =
    field_of(bank_value[2], IPR_FIELD_LO_LSB);
  // capture group
  assign capture5_priority = field_of(bank_value[3], IPR_FIELD_HI_LSB);
  assign capture4_priority = field_of(bank_value[3], IPR_FIELD_MH_LSB);
  assign capture3_priority = field_of(bank_value[3], IPR_FIELD_ML_LSB);
  assign dma_ch3_done_priority =
    field_of(bank_value[3], IPR_FIELD_LO_LSB);

  // source i uses field i: register i/4, highest field first;
  // the stride is one field plus its unused gap bit, so the gap
  // bits never reach the gating logic
  always_comb
  begin
    prio_flat = '0;
    for (int i = 0; i < IPR_SRC_COUNT; i++)
      prio_flat[i*IPR_FIELD_W +: IPR_FIELD_W] = field_of(
        bank_value[i / IPR_FIELDS_PER_REG],
        IPR_FIELD_HI_LSB -
        (i % IPR_FIELDS_PER_REG) * (IPR_FIELD_W + 1));
  end

  // ---------------------------------------------------------------
  // request gating
  // ---------------------------------------------------------------
  // a request trails its flag by one cycle
  ipr_gate u_gate
  (
    .clk(clk),
    .rst_b(rst_b),
    .src_flag(src_flag),
    .src_prio(prio_flat),
    .irq_request(irq_request)
  );

endmodule : ipr_top
`default_nettype wire

// [test/ipr_top_checker.sv]
// ipr_top_checker: bus and gating properties of the priority bank
// assumes: bound to ipr_top, one clock, async active-low reset
`timescale 1ns/100ps
`default_nettype none
module ipr_top_checker
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [15:0] src_flag,
  input wire logic [15:0] irq_request,
  input wire ipr_pkg::ipr_prio_t timer4_priority,
  input wire ipr_pkg::ipr_prio_t dma_ch3_done_priority
);
  import ipr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_gap_zero: assert property (rvalid |-> (rdata & 32'hFFFF8888) == 0)
    else $error("gap bits set in read data");
  a_rst_field: assert property ($rose(rst_b) |->
    timer4_priority == 3'h4 && dma_ch3_done_priority == 3'h4)
    else $error("field not at reset level");
  a_off_blocks: assert property (timer4_priority == 3'h0 |=>
    !irq_request[0]) else $error("disabled source requests");
  a_on_passes: assert property (src_flag[0] && timer4_priority != 0
    |=> irq_request[0]) else $error("enabled source lost");
  a_cap_gate: assert property (irq_request[15] |-> $past(src_flag[15]) &&
    $past(dma_ch3_done_priority) != 3'h0)
    else $error("request without cause");
  a_idle_quiet: assert property (!src_flag[0] |=> !irq_request[0])
    else $error("request without flag");
  a_rd_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  a_rd_lat: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_ar_busy: assert property (rvalid |-> !arready)
    else $error("read taken while busy");
  a_b_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("write answer dropped");
  c_top: cover property (timer4_priority == 3'h7 && src_flag[0]);
  c_wr: cover property (bvalid && bready);
  c_rd: cover property (rvalid && rready && rdata[14:12] == 3'h0);
endmodule : ipr_top_checker
bind ipr_top ipr_top_checker u_chk (.clk(clk), .rst_b(rst_b),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .rdata(rdata), .bvalid(bvalid), .bready(bready), .src_flag(src_flag),
  .irq_request(irq_request), .timer4_priority(timer4_priority),
  .dma_ch3_done_priority(dma_ch3_done_priority));
`default_nettype wire

// [test/tb.sv]
// tb: self-checking bench for the priority register bank
// assumes: ipr_top with default address width, 50 ns clock
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ipr_pkg::*;
  logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, seed, v;
  logic [3:0] wstrb;
  logic [15:0] src_flag;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [15:0] irq_request;
  wire logic [47:0] pr;
  int fail_count, tests_run;
  int mdl [4];
  logic [7:0] offs [4] = '{IPR_OFF_GROUP_6, IPR_OFF_GROUP_7,
    IPR_OFF_GROUP_8, IPR_OFF_GROUP_CAPTURE};
  ipr_top u_dut
  (
    .clk(clk), .rst_b(rst_b), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .src_flag(src_flag), .irq_request(irq_request),
    .timer4_priority(pr[2:0]), .compare4_priority(pr[5:3]),
    .compare3_priority(pr[8:6]), .dma_ch2_done_priority(pr[11:9]),
    .serial2_tx_priority(pr[14:12]), .serial2_rx_priority(pr[17:15]),
    .ext_irq2_priority(pr[20:18]), .timer5_priority(pr[23:21]),
    .can1_event_priority(pr[26:24]), .can1_rx_ready_priority(pr[29:27]),
    .spi2_event_priority(pr[32:30]), .spi2_error_priority(pr[35:33]),
    .capture5_priority(pr[38:36]), .capture4_priority(pr[41:39]),
    .capture3_priority(pr[44:42]), .dma_ch3_done_priority(pr[47:45])
  );
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // model store: only mapped words, low two lanes, field bits only
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    logic ok;
    ok = a < 8'h10 && a[1:0] == 2'b00;
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    // only the watchdog ends a write that is never answered
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    chk(32'(bresp), 32'(ok ? IPR_RESP_OKAY : IPR_RESP_SLVERR));
    if (ok && s[0]) mdl[a>>2][7:0] = d[7:0];
    if (ok && s[1]) mdl[a>>2][15:8] = d[15:8];
    if (ok) mdl[a>>2] &= 32'h7777;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ok;
    ok = a < 8'h10 && a[1:0] == 2'b00;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    chk(rdata, ok ? 32'(mdl[a>>2]) : 32'h0);
    chk(32'(rresp), 32'(ok ? IPR_RESP_OKAY : IPR_RESP_SLVERR));
  endtask : rd
  // one edge lets flag or register changes reach the request outputs
  task automatic cmp();
    logic [15:0] e;
    logic [2:0] f;
    @(posedge clk);
    @(negedge clk);
    for (int i = 0; i < 16; i++)
    begin
      f = 3'(mdl[i/4] >> (12 - 4 * (i % 4)));
      chk(32'(pr[3*i +: 3]), 32'(f));
      e[i] = src_flag[i] && f != 3'h0;
    end
    chk(32'(irq_request), 32'(e));
  endtask : cmp
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  // ---------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // whole run is well under a thousand cycles
  initial
  begin
    #(50 * 4000);
    fail_count++;
    final_report();
  end
  initial
  begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, wstrb, src_flag} = 68'h0;
    seed = 32'h20F80A82;
    for (int r = 0; r < 4; r++) mdl[r] = 32'h4444;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    for (int r = 0; r < 4; r++) rd(offs[r]);
    cmp();
    $display("reset values done");
    for (int c = 0; c < 8; c++)
    begin
      for (int r = 0; r < 4; r++) wr(offs[r], 32'(c * 16'h1111), 4'h3);
      src_flag <= 16'hFFFF;
      rd(offs[c % 4]);
      cmp();
    end
    $display("priority codes done");
    // random words hit gap bits, high half, strobes and unmapped words
    for (int k = 0; k < 32; k++)
    begin
      v = xs();
      wr({3'h0, v[4:2], 2'h0}, xs(), v[8:5]);
      v = xs();
      src_flag <= v[15:0];
      rd({3'h0, v[20:18], 2'h0});
      cmp();
    end
    $display("random access done");
    final_report();
  end
endmodule : tb
`default_nettype wire
